// ### sct_pkg.sv
// constants and types for the slow clock elapsed timer
package sct_pkg;

   // ****************************************
   // bus and register map
   // ****************************************
   localparam int unsigned     SCT_ADDR_W        = 8;
   localparam int unsigned     SCT_DATA_W        = 32;
   localparam logic [7:0]      SCT_OFF_MODE      = 8'h00;
   localparam logic [7:0]      SCT_OFF_ALARM     = 8'h04;
   localparam logic [7:0]      SCT_OFF_COUNT     = 8'h08;
   localparam logic [7:0]      SCT_OFF_STATUS    = 8'h0C;
   localparam logic [1:0]      SCT_RESP_OKAY     = 2'h0;
   localparam logic [1:0]      SCT_RESP_SLVERR   = 2'h2;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int unsigned     SCT_PRES_W        = 16;
   localparam int unsigned     SCT_CNT_W         = 32;
   localparam int unsigned     SCT_ALM_IE_BIT    = 16;
   localparam int unsigned     SCT_INC_IE_BIT    = 17;
   localparam int unsigned     SCT_RESTART_BIT   = 18;
   localparam int unsigned     SCT_ALM_FLAG_BIT  = 0;
   localparam int unsigned     SCT_INC_FLAG_BIT  = 1;
   localparam logic [31:0]     SCT_MODE_RESET    = 32'h0000_8000;
   localparam logic [31:0]     SCT_ALARM_RESET   = 32'hFFFF_FFFF;
   localparam logic [31:0]     SCT_COUNT_RESET   = 32'h0000_0000;
   localparam logic [15:0]     SCT_PRES_RELOAD_RESET = SCT_MODE_RESET[15:0] - 16'h0001;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned     SCT_CLK_HZ        = 20_000_000;
   localparam int unsigned     SCT_SLOW_HZ       = 32_768;
   localparam int unsigned     SCT_SLOW_DIV      = SCT_CLK_HZ / SCT_SLOW_HZ;
   localparam int unsigned     SCT_DIV_W         = 16;
   localparam logic [1:0]      SCT_LATE_TICKS    = 2'h2;

   typedef struct packed {
      logic                    inc_irq_enable;
      logic                    alarm_irq_enable;
      logic [15:0]             prescale_value;
   } sct_mode_t;

endpackage

// ### sct_timer.sv
// slow clock elapsed timer with axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none

//Contract
//- 32-bit counter advances on each prescaler period
//- period is prescale value, zero means 65536
//- prescale 0x8000 gives 32768 cycles per count
//- counter wraps from maximum to zero
//- counter matching alarm plus one sets sticky alarm flag
//- compare value is stored alarm plus one
//- alarm register resets to all ones
//- each increment sets sticky increment flag
//- status read clears both flags
//- read clear lands two slow cycles late
//- interrupt may linger two slow cycles
//- alarm enable gates alarm flag to interrupt
//- increment enable gates increment flag to interrupt
//- restart bit reloads prescaler, clears counter
//- restart lands two slow cycles late
module sct_timer
   import sct_pkg::*;
#(
   parameter int unsigned SLOW_DIV = SCT_SLOW_DIV
)(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [SCT_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [SCT_ADDR_W-1:0] s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic                       irq
);

   // ****************************************
   // state
   // ****************************************
   logic                   aw_have_r,  aw_have_nxt;
   logic [SCT_ADDR_W-1:0]  aw_addr_r,  aw_addr_nxt;
   logic                   w_have_r,   w_have_nxt;
   logic [31:0]            w_data_r,   w_data_nxt;
   logic [3:0]             w_strb_r,   w_strb_nxt;
   logic                   awready_r,  awready_nxt;
   logic                   wready_r,   wready_nxt;
   logic                   bvalid_r,   bvalid_nxt;
   logic [1:0]             bresp_r,    bresp_nxt;
   logic                   arready_r,  arready_nxt;
   logic                   rvalid_r,   rvalid_nxt;
   logic [31:0]            rdata_r,    rdata_nxt;
   logic [1:0]             rresp_r,    rresp_nxt;

   sct_mode_t              mode_r,     mode_nxt;
   logic [31:0]            alarm_r,    alarm_nxt;
   logic [31:0]            count_r,    count_nxt;
   logic [15:0]            pres_r,     pres_nxt;
   logic                   alm_flag_r, alm_flag_nxt;
   logic                   inc_flag_r, inc_flag_nxt;
   logic                   clr_pend_r, clr_pend_nxt;
   logic [1:0]             clr_ticks_r, clr_ticks_nxt;
   logic                   rst_pend_r, rst_pend_nxt;
   logic [1:0]             rst_ticks_r, rst_ticks_nxt;
   logic                   irq_r,      irq_nxt;
   logic [SCT_DIV_W-1:0]   div_r,      div_nxt;
   logic                   tick_r,     tick_nxt;

   logic                   wr_commit;
   logic                   wr_mode;
   logic                   wr_alarm;
   logic                   rd_take;
   logic                   rd_status;
   logic                   rst_apply;
   logic                   clr_apply;
   logic                   inc_event;
   logic                   alarm_match;
   logic [31:0]            alarm_cmp;
   logic [31:0]            mode_word;
   logic [31:0]            mode_wr;

   function automatic logic [31:0] sct_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign mode_word   = {13'h0000, 1'b0, mode_r.inc_irq_enable, mode_r.alarm_irq_enable, mode_r.prescale_value};
   assign mode_wr     = sct_merge(mode_word, w_data_r, w_strb_r);
   assign wr_commit   = aw_have_r && w_have_r && !bvalid_r;
   assign wr_mode     = wr_commit && (aw_addr_r == SCT_OFF_MODE);
   assign wr_alarm    = wr_commit && (aw_addr_r == SCT_OFF_ALARM);
   assign rd_take     = s_axi_arvalid && arready_r;
   assign rd_status   = rd_take && (s_axi_araddr == SCT_OFF_STATUS);
   assign alarm_cmp   = 32'(alarm_r + 32'h0000_0001);
   assign alarm_match = (count_r == alarm_cmp);
   assign rst_apply   = tick_r && rst_pend_r && (rst_ticks_r == SCT_LATE_TICKS - 2'h1);
   assign clr_apply   = tick_r && clr_pend_r && (clr_ticks_r == SCT_LATE_TICKS - 2'h1);
   assign inc_event   = tick_r && !rst_apply && (pres_r == 16'h0000);

   // ****************************************
   // axi4-lite slave
   // ****************************************
   always_comb begin
      aw_have_nxt = aw_have_r;
      aw_addr_nxt = aw_addr_r;
      w_have_nxt  = w_have_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r;
      bresp_nxt   = bresp_r;
      arready_nxt = arready_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      if (s_axi_awvalid && awready_r) begin
         aw_have_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_have_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (wr_commit) begin
         aw_have_nxt = 1'b0;
         w_have_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         // read-only offsets accept and drop the write; only holes get an error
         bresp_nxt   = (aw_addr_r[7:4] == 4'h0 && aw_addr_r[1:0] == 2'h0) ? SCT_RESP_OKAY : SCT_RESP_SLVERR;
      end
      // new address or data only once the last response is gone
      awready_nxt = !aw_have_nxt && !bvalid_nxt;
      wready_nxt  = !w_have_nxt && !bvalid_nxt;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt  = 1'b0;
         arready_nxt = 1'b1;
      end
      if (rd_take) begin
         rvalid_nxt  = 1'b1;
         arready_nxt = 1'b0;
         rresp_nxt   = SCT_RESP_OKAY;
         case (s_axi_araddr)
            SCT_OFF_MODE : begin
               rdata_nxt = mode_word;
            end
            SCT_OFF_ALARM : begin
               rdata_nxt = alarm_r;
            end
            SCT_OFF_COUNT : begin
               // count only changes on a clocked tick, so no bit is ever caught mid-change
               rdata_nxt = count_r;
            end
            SCT_OFF_STATUS : begin
               rdata_nxt = {30'h0000_0000, inc_flag_r, alm_flag_r};
            end
            default : begin
               rdata_nxt = 32'h0000_0000;
               rresp_nxt = SCT_RESP_SLVERR;
            end
         endcase
      end
      // address is taken only while no read data is waiting
      arready_nxt = !rvalid_nxt;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_have_r  <= 1'b0;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= SCT_RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= SCT_RESP_OKAY;
      end else begin
         aw_have_r <= aw_have_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_have_r  <= w_have_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   // ****************************************
   // slow clock, prescaler, counter and flags
   // ****************************************
   always_comb begin
      div_nxt       = (div_r == SCT_DIV_W'(SLOW_DIV - 1)) ? '0 : SCT_DIV_W'(div_r + 1'b1);
      tick_nxt      = (div_r == SCT_DIV_W'(SLOW_DIV - 1));
      mode_nxt      = mode_r;
      alarm_nxt     = alarm_r;
      count_nxt     = count_r;
      pres_nxt      = pres_r;
      rst_pend_nxt  = rst_pend_r;
      rst_ticks_nxt = rst_ticks_r;
      clr_pend_nxt  = clr_pend_r;
      clr_ticks_nxt = clr_ticks_r;
      alm_flag_nxt  = alm_flag_r;
      inc_flag_nxt  = inc_flag_r;
      if (wr_mode) begin
         mode_nxt.prescale_value   = mode_wr[15:0];
         mode_nxt.alarm_irq_enable = mode_wr[SCT_ALM_IE_BIT];
         mode_nxt.inc_irq_enable   = mode_wr[SCT_INC_IE_BIT];
      end
      if (wr_alarm) begin
         alarm_nxt = sct_merge(alarm_r, w_data_r, w_strb_r);
      end
      // restart waits two slow ticks, as a real slow-clock crossing would
      if (rst_apply) begin
         rst_pend_nxt = 1'b0;
         count_nxt    = 32'h0000_0000;
         pres_nxt     = 16'(mode_r.prescale_value - 16'h0001);
      end else if (rst_pend_r && tick_r) begin
         rst_ticks_nxt = 2'(rst_ticks_r + 2'h1);
      end
      if (wr_mode && mode_wr[SCT_RESTART_BIT] && !rst_pend_r) begin
         rst_pend_nxt  = 1'b1;
         rst_ticks_nxt = 2'h0;
      end
      if (tick_r && !rst_apply) begin
         if (pres_r == 16'h0000) begin
            // zero reloads to 0xFFFF, giving 65536 slow cycles per count
            pres_nxt  = 16'(mode_r.prescale_value - 16'h0001);
            count_nxt = 32'(count_r + 32'h0000_0001);
         end else begin
            pres_nxt = 16'(pres_r - 16'h0001);
         end
      end
      if (clr_apply) begin
         clr_pend_nxt = 1'b0;
         alm_flag_nxt = 1'b0;
         inc_flag_nxt = 1'b0;
      end else if (clr_pend_r && tick_r) begin
         clr_ticks_nxt = 2'(clr_ticks_r + 2'h1);
      end
      if (rd_status && !clr_pend_r) begin
         clr_pend_nxt  = 1'b1;
         clr_ticks_nxt = 2'h0;
      end
      // sets come last so an event in the clearing cycle is kept
      if (alarm_match) begin
         alm_flag_nxt = 1'b1;
      end
      if (inc_event) begin
         inc_flag_nxt = 1'b1;
      end
      irq_nxt = (alm_flag_nxt && mode_nxt.alarm_irq_enable)
             || (inc_flag_nxt && mode_nxt.inc_irq_enable);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r       <= '0;
         tick_r      <= 1'b0;
         mode_r      <= sct_mode_t'(SCT_MODE_RESET[17:0]);
         alarm_r     <= SCT_ALARM_RESET;
         count_r     <= SCT_COUNT_RESET;
         pres_r      <= SCT_PRES_RELOAD_RESET;
         rst_pend_r  <= 1'b0;
         rst_ticks_r <= 2'h0;
         clr_pend_r  <= 1'b0;
         clr_ticks_r <= 2'h0;
         alm_flag_r  <= 1'b0;
         inc_flag_r  <= 1'b0;
         irq_r       <= 1'b0;
      end else begin
         div_r       <= div_nxt;
         tick_r      <= tick_nxt;
         mode_r      <= mode_nxt;
         alarm_r     <= alarm_nxt;
         count_r     <= count_nxt;
         pres_r      <= pres_nxt;
         rst_pend_r  <= rst_pend_nxt;
         rst_ticks_r <= rst_ticks_nxt;
         clr_pend_r  <= clr_pend_nxt;
         clr_ticks_r <= clr_ticks_nxt;
         alm_flag_r  <= alm_flag_nxt;
         inc_flag_r  <= inc_flag_nxt;
         irq_r       <= irq_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign irq           = irq_r;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_restart_asked;
      wr_mode && mode_wr[SCT_RESTART_BIT] && !rst_pend_r;
   endsequence
   sequence s_no_tick_wait;
      !tick_r [*2];
   endsequence

   chk_inc_step:    assert property (inc_event && count_r != 32'hFFFF_FFFF |=> count_r == $past(count_r) + 32'h1)
      else $error("count did not step by one");
   chk_count_wrap:  assert property (inc_event && count_r == 32'hFFFF_FFFF |=> count_r == 32'h0)
      else $error("count did not wrap to zero");
   chk_pres_reload: assert property (inc_event |=> pres_r == 16'($past(mode_r.prescale_value) - 16'h0001))
      else $error("prescaler reload wrong");
   chk_reset_vals:  assert property ($rose(aresetn) |-> alarm_r == 32'hFFFF_FFFF && mode_r.prescale_value == 16'h8000)
      else $error("reset values wrong");
   chk_alarm_cmp:   assert property (count_r == 32'(alarm_r + 32'h1) |=> alm_flag_r)
      else $error("alarm match did not set flag");
   chk_inc_flag:    assert property (inc_event |=> inc_flag_r ##1 1'b1)
      else $error("increment did not set flag");
   chk_irq_or:      assert property (irq_r == ((alm_flag_r && mode_r.alarm_irq_enable) || (inc_flag_r && mode_r.inc_irq_enable)))
      else $error("irq not the gated or of flags");
   chk_irq_linger:  assert property (rd_status && !clr_pend_r && irq_r ##1 s_no_tick_wait |-> irq_r)
      else $error("irq dropped before slow ticks");
   chk_clear_late:  assert property (rd_status && !clr_pend_r |=> clr_pend_r && clr_ticks_r == 2'h0)
      else $error("status clear not scheduled late");
   chk_restart:     assert property (s_restart_asked |=> rst_pend_r && rst_ticks_r == 2'h0)
      else $error("restart applied too early");
   chk_restart_clr: assert property (rst_apply |=> count_r == 32'h0 && !rst_pend_r)
      else $error("restart did not clear count");

endmodule

`default_nettype wire

// ### testbench.sv
// self-checking testbench for the slow clock elapsed timer
`timescale 1ns/100ps
`default_nettype none
module testbench
   import sct_pkg::*;
;
   // ****************************************
   // signals
   // ****************************************
   localparam logic [31:0] PRES    = 32'h0000_000A;
   localparam logic [31:0] RESTART = 32'h0004_0000;
   localparam logic [31:0] ALM_IE  = 32'h0001_0000;
   localparam logic [31:0] INC_IE  = 32'h0002_0000;
   logic                  aclk;
   logic                  aresetn;
   logic [SCT_ADDR_W-1:0] awaddr;
   logic                  awvalid;
   logic                  awready;
   logic [31:0]           wdata;
   logic [3:0]            wstrb;
   logic                  wvalid;
   logic                  wready;
   logic [1:0]            bresp;
   logic                  bvalid;
   logic                  bready;
   logic [SCT_ADDR_W-1:0] araddr;
   logic                  arvalid;
   logic                  arready;
   logic [31:0]           rdata;
   logic [1:0]            rresp;
   logic                  rvalid;
   logic                  rready;
   logic                  irq;
   logic [31:0]           d;
   logic [31:0]           c1;
   logic [1:0]            r;
   int                    num_errors;
   int                    compares;

   // slow tick every 4 clocks keeps counts short; prescale 10 gives 40 clocks a count
   sct_timer #(.SLOW_DIV(4)) dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq(irq));

   initial aclk = 1'b0;
   always #25 aclk = ~aclk;

   // ****************************************
   // bus and check tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // each bus task opens with an edge so a ready is never lowered and raised in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string m);
      logic [31:0] v;
      logic [1:0]  q;
      rd(a, v, q);
      chk(v, exp, m);
   endtask

   // polling rather than a fixed wait: the count phase depends on bus latency
   task automatic wait_cnt(input logic [31:0] v);
      logic [31:0] c;
      logic [31:0] p;
      logic [1:0]  q;
      rd(SCT_OFF_COUNT, p, q);
      do begin
         c = p;
         rd(SCT_OFF_COUNT, p, q);
      end while (c !== v || p !== v);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task t_regs;
      rchk(SCT_OFF_MODE, SCT_MODE_RESET, "mode reset");
      rchk(SCT_OFF_ALARM, SCT_ALARM_RESET, "alarm reset");
      rchk(SCT_OFF_COUNT, SCT_COUNT_RESET, "count reset");
      rchk(SCT_OFF_STATUS, 32'h0000_0001, "all ones alarm matches zero");
      chk(irq, 32'h0, "irq masked");
      rd(8'h10, d, r);
      chk(r, SCT_RESP_SLVERR, "hole read resp");
      chk(d, 32'h0, "hole read data");
      wr(8'h10, 32'h0000_00FF, 4'hF, r);
      chk(r, SCT_RESP_SLVERR, "hole write resp");
      wr(SCT_OFF_COUNT, 32'h0000_1234, 4'hF, r);
      chk(r, SCT_RESP_OKAY, "count write resp");
      rchk(SCT_OFF_COUNT, 32'h0000_0000, "count read only");
      wr(SCT_OFF_ALARM, 32'h1234_5678, 4'h3, r);
      rchk(SCT_OFF_ALARM, 32'hFFFF_5678, "byte strobes");
      wr(SCT_OFF_ALARM, 32'h0000_0002, 4'hF, r);
   endtask

   task t_rate;
      wr(SCT_OFF_MODE, PRES | RESTART, 4'hF, r);
      rchk(SCT_OFF_MODE, PRES, "restart bit reads zero");
      cyc(12);
      rd(SCT_OFF_COUNT, c1, r);
      cyc(117);
      rd(SCT_OFF_COUNT, d, r);
      chk(d - c1, 32'h3, "count rate");
   endtask

   task t_alarm;
      wr(SCT_OFF_MODE, PRES | RESTART, 4'hF, r);
      cyc(12);
      rd(SCT_OFF_STATUS, d, r);
      cyc(12);
      wait_cnt(32'h2);
      rchk(SCT_OFF_STATUS, 32'h0000_0002, "no alarm at stored value");
      wait_cnt(32'h3);
      rchk(SCT_OFF_STATUS, 32'h0000_0003, "alarm and increment");
      rchk(SCT_OFF_STATUS, 32'h0000_0003, "clear still pending");
      cyc(12);
      rchk(SCT_OFF_STATUS, 32'h0000_0001, "increment cleared");
   endtask

   task t_irq;
      int n;
      chk(irq, 32'h0, "alarm flag masked");
      wr(SCT_OFF_MODE, PRES | ALM_IE, 4'hF, r);
      cyc(2);
      chk(irq, 32'h1, "alarm irq");
      rd(SCT_OFF_COUNT, d, r);
      chk(d == 32'h0, 32'h0, "zero restart bit keeps count");
      wr(SCT_OFF_ALARM, 32'hFFFF_FFF0, 4'hF, r);
      rd(SCT_OFF_STATUS, d, r);
      chk(irq, 32'h1, "irq lingers");
      cyc(12);
      chk(irq, 32'h0, "alarm irq cleared");
      wr(SCT_OFF_MODE, PRES | INC_IE, 4'hF, r);
      rd(SCT_OFF_STATUS, d, r);
      cyc(12);
      n = 0;
      while (irq !== 1'b1 && n < 60) begin
         @(posedge aclk);
         n++;
      end
      chk(irq, 32'h1, "increment irq");
      rd(SCT_OFF_STATUS, d, r);
      cyc(12);
      chk(irq, 32'h0, "increment irq cleared");
   endtask

   task t_restart;
      wr(SCT_OFF_MODE, PRES | RESTART, 4'hF, r);
      rd(SCT_OFF_COUNT, d, r);
      chk(d == 32'h0, 32'h0, "restart not yet landed");
      cyc(12);
      rchk(SCT_OFF_COUNT, 32'h0000_0000, "restart clears count");
      wr(SCT_OFF_MODE, RESTART, 4'hF, r);
      cyc(450);
      rchk(SCT_OFF_COUNT, 32'h0000_0000, "zero prescale is long");
   endtask

   task end_sim;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      num_errors = 0;
      compares = 0;
      aresetn = 1'b0;
      awaddr = 8'h00;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 8'h00;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_rate();
      t_alarm();
      t_irq();
      t_restart();
      end_sim();
   end

   // whole run needs under 2000 clocks
   initial begin
      repeat (8000) @(posedge aclk);
      num_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
